// ===== core/pps_pin_cell.sv
// Purpose: Function of one port pin from its availability and port settings.
// Assumes: All inputs are steady levels from registers of the parent.
// Notes: Purely combinational; the parent registers the results.

`timescale 1ns/1ps

module pps_pin_cell (
  input wire logic avail_i,
  input wire logic input_only_i,
  input wire logic open_drain_i,
  input wire logic data_i,
  input wire logic dir_i,
  input wire logic pu_en_i,
  output logic out_o,
  output logic oe_o,
  output logic pu_o
);

  // A claimed pin neither drives nor pulls; an open-drain pin only pulls low.
  always_comb begin
    out_o = 1'b0;
    oe_o = 1'b0;
    pu_o = 1'b0;
    if (avail_i && !input_only_i) begin
      if (open_drain_i) begin
        oe_o = dir_i & ~data_i;
      end else begin
        out_o = data_i;
        oe_o = dir_i;
        pu_o = pu_en_i & ~dir_i;
      end
    end
  end

endmodule

// ===== core/pps_pkg.sv
// Purpose: Shared constants and types for the port pin function select block.
// Assumes: AHB-Lite slave with 32-bit data and word-aligned registers.
// Notes: Offsets are byte addresses within the block's window.

package pps_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin layout of the six-pin port.
  localparam int unsigned PPS_NPINS = 6;
  localparam int unsigned PPS_NLOW = 5;
  localparam int unsigned PPS_FOURTH = 3;
  localparam int unsigned PPS_FIFTH = 4;
  localparam int unsigned PPS_TOP = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets, as byte addresses.
  localparam logic [7:0] PPS_OFF_DATA = 8'h00;
  localparam logic [7:0] PPS_OFF_DIR = 8'h04;
  localparam logic [7:0] PPS_OFF_PULLUP = 8'h08;
  localparam logic [7:0] PPS_OFF_PIN = 8'h0c;
  localparam logic [7:0] PPS_OFF_STAT = 8'h10;

  // Register indices produced by the address decoder.
  localparam logic [2:0] PPS_IDX_DATA = 3'h0;
  localparam logic [2:0] PPS_IDX_DIR = 3'h1;
  localparam logic [2:0] PPS_IDX_PULLUP = 3'h2;
  localparam logic [2:0] PPS_IDX_PIN = 3'h3;
  localparam logic [2:0] PPS_IDX_STAT = 3'h4;
  localparam logic [2:0] PPS_IDX_NONE = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values of the software registers.
  localparam logic [5:0] PPS_DATA_RST = 6'h00;
  localparam logic [5:0] PPS_DIR_RST = 6'h00;
  localparam logic [4:0] PPS_PULLUP_RST = 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions of the status register.
  localparam int unsigned PPS_STAT_CLK_LSB = 0;
  localparam int unsigned PPS_STAT_EXTRST = 3;
  localparam int unsigned PPS_STAT_FULL = 4;
  localparam int unsigned PPS_STAT_AVAIL_LSB = 8;

  // The transfer-type bit that marks NONSEQ or SEQ.
  localparam int unsigned PPS_HTRANS_ACTIVE = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Clock source options.
  typedef enum logic [2:0] {
    PPS_CLK_EXT_XTAL = 3'b000,
    PPS_CLK_EXT_LF_XTAL = 3'b001,
    PPS_CLK_CERAMIC = 3'b010,
    PPS_CLK_EXT_RC = 3'b011,
    PPS_CLK_EXT_CLOCK = 3'b100,
    PPS_CLK_INT_RC = 3'b101
  } pps_clk_opt_type;

endpackage

// ===== core/pps_port_pin_function_select.sv
// Purpose: Pin function select for a six-pin general port, with AHB-Lite registers.
// Assumes: Reset-enable, clock option and variant straps are static in operation.
// Notes: Pin enables are cut by a reset condition without help from the clock.
// Function
// - Lower five pins bidirectional, each own pull-up.
// - Top pin input only, or open-drain on full.
// - Any reset condition tri-states all pins, clocklessly.
// - External reset enabled: top pin is reset only.
// - External reset disabled: top pin back to port.
// - Crystal and resonator options claim fourth, fifth pins.
// - RC and external clock claim fourth pin only.
// - Internal RC claims nothing; pins stay port.

`timescale 1ns/1ps

module pps_port_pin_function_select (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic cfg_ext_rst_en_i,
  input wire logic [2:0] cfg_clk_opt_i,
  input wire logic cfg_full_variant_i,
  input wire logic [5:0] port_pins_i,
  output logic [5:0] port_pins_o,
  output logic [5:0] port_pins_oe_o,
  output logic [5:0] port_pins_pu_o,
  output logic osc_amp_input_sel_o,
  output logic osc_amp_output_sel_o,
  output logic ext_reset_req_o,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding functions.

  // Returns {fifth claimed, fourth claimed} for a clock option.
  function automatic logic [1:0] pps_claim(input logic [2:0] opt);
    logic [1:0] claim;
    claim = 2'b00;
    unique case (opt)
      pps_pkg::PPS_CLK_EXT_XTAL,
      pps_pkg::PPS_CLK_EXT_LF_XTAL,
      pps_pkg::PPS_CLK_CERAMIC: begin
        claim = 2'b11;
      end
      pps_pkg::PPS_CLK_EXT_RC,
      pps_pkg::PPS_CLK_EXT_CLOCK: begin
        claim = 2'b01;
      end
      pps_pkg::PPS_CLK_INT_RC: begin
        claim = 2'b00;
      end
      default: begin
        claim = 2'b00;
      end
    endcase
    return claim;
  endfunction

  // Maps a byte offset to a register index, or to none when unmapped.
  function automatic logic [2:0] pps_reg_index(input logic [31:0] addr);
    logic [2:0] idx;
    idx = pps_pkg::PPS_IDX_NONE;
    if (addr[31:8] == 24'h000000) begin
      unique case (addr[7:0])
        pps_pkg::PPS_OFF_DATA: idx = pps_pkg::PPS_IDX_DATA;
        pps_pkg::PPS_OFF_DIR: idx = pps_pkg::PPS_IDX_DIR;
        pps_pkg::PPS_OFF_PULLUP: idx = pps_pkg::PPS_IDX_PULLUP;
        pps_pkg::PPS_OFF_PIN: idx = pps_pkg::PPS_IDX_PIN;
        pps_pkg::PPS_OFF_STAT: idx = pps_pkg::PPS_IDX_STAT;
        default: idx = pps_pkg::PPS_IDX_NONE;
      endcase
    end
    return idx;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Static configuration straps.

  logic cfg_ext_rst_r;
  logic cfg_ext_rst_nxt;
  logic [2:0] cfg_clk_r;
  logic [2:0] cfg_clk_nxt;
  logic cfg_full_r;
  logic cfg_full_nxt;

  // Straps are loaded on every edge while reset is held and kept after it.
  always_comb begin
    cfg_ext_rst_nxt = cfg_ext_rst_r;
    cfg_clk_nxt = cfg_clk_r;
    cfg_full_nxt = cfg_full_r;
    if (!rst_n_i) begin
      cfg_ext_rst_nxt = cfg_ext_rst_en_i;
      cfg_clk_nxt = cfg_clk_opt_i;
      cfg_full_nxt = cfg_full_variant_i;
    end
  end

  // Registers the straps; reset loads them even while the clock enable is low.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || ce_i) begin
      cfg_ext_rst_r <= cfg_ext_rst_nxt;
      cfg_clk_r <= cfg_clk_nxt;
      cfg_full_r <= cfg_full_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin availability from the straps.

  logic [1:0] claim;
  logic [5:0] avail;
  logic [5:0] input_only;
  logic [5:0] open_drain;

  // The top pin leaves the port while external reset is on; the lowest three pins always stay port.
  assign claim = pps_claim(cfg_clk_r);
  assign avail[2:0] = 3'b111;
  assign avail[pps_pkg::PPS_FOURTH] = ~claim[0];
  assign avail[pps_pkg::PPS_FIFTH] = ~claim[1];
  assign avail[pps_pkg::PPS_TOP] = ~cfg_ext_rst_r;

  // Top pin is input only on the reduced variant, open drain on the full one.
  assign input_only = {~cfg_full_r, 5'h00};
  assign open_drain = {cfg_full_r, 5'h00};

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave.

  logic wr_pend_r;
  logic wr_pend_nxt;
  logic [2:0] wr_idx_r;
  logic [2:0] wr_idx_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic hreadyout_r;
  logic hreadyout_nxt;
  logic hresp_r;
  logic hresp_nxt;
  logic accept;
  logic [2:0] rd_idx;

  // Software port registers.
  logic [5:0] data_r;
  logic [5:0] data_nxt;
  logic [5:0] dir_r;
  logic [5:0] dir_nxt;
  logic [4:0] pullup_r;
  logic [4:0] pullup_nxt;
  logic [5:0] pin_in_r;
  logic [5:0] pin_in_nxt;

  // An address phase is taken when selected, active and the bus is ready.
  assign accept = hsel_i & htrans_i[pps_pkg::PPS_HTRANS_ACTIVE] & hready_i;
  assign rd_idx = pps_reg_index(haddr_i);

  // Read data is prepared in the address phase so the slave needs no wait.
  always_comb begin
    wr_pend_nxt = 1'b0;
    wr_idx_nxt = wr_idx_r;
    hrdata_nxt = hrdata_r;
    hreadyout_nxt = 1'b1;
    hresp_nxt = 1'b0;
    if (!rst_n_i) begin
      wr_idx_nxt = pps_pkg::PPS_IDX_NONE;
      hrdata_nxt = 32'h00000000;
    end else if (accept) begin
      hrdata_nxt = 32'h00000000;
      if (hwrite_i) begin
        wr_pend_nxt = 1'b1;
        wr_idx_nxt = rd_idx;
      end else begin
        unique case (rd_idx)
          pps_pkg::PPS_IDX_DATA: hrdata_nxt[5:0] = data_r;
          pps_pkg::PPS_IDX_DIR: hrdata_nxt[5:0] = dir_r;
          pps_pkg::PPS_IDX_PULLUP: hrdata_nxt[4:0] = pullup_r;
          pps_pkg::PPS_IDX_PIN: hrdata_nxt[5:0] = pin_in_r & avail;
          pps_pkg::PPS_IDX_STAT: begin
            hrdata_nxt[pps_pkg::PPS_STAT_CLK_LSB +: 3] = cfg_clk_r;
            hrdata_nxt[pps_pkg::PPS_STAT_EXTRST] = cfg_ext_rst_r;
            hrdata_nxt[pps_pkg::PPS_STAT_FULL] = cfg_full_r;
            hrdata_nxt[pps_pkg::PPS_STAT_AVAIL_LSB +: 6] = avail;
          end
          default: hrdata_nxt = 32'h00000000;
        endcase
      end
    end
  end

  // Registers the bus state.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || ce_i) begin
      wr_pend_r <= wr_pend_nxt;
      wr_idx_r <= wr_idx_nxt;
      hrdata_r <= hrdata_nxt;
      hreadyout_r <= hreadyout_nxt;
      hresp_r <= hresp_nxt;
    end
  end

  assign hrdata_o = hrdata_r;
  assign hreadyout_o = hreadyout_r;
  assign hresp_o = hresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Port registers, written in the data phase.

  // Writes land at the end of the data phase; the pin input is sampled.
  always_comb begin
    data_nxt = data_r;
    dir_nxt = dir_r;
    pullup_nxt = pullup_r;
    pin_in_nxt = port_pins_i;
    if (!rst_n_i) begin
      data_nxt = pps_pkg::PPS_DATA_RST;
      dir_nxt = pps_pkg::PPS_DIR_RST;
      pullup_nxt = pps_pkg::PPS_PULLUP_RST;
      pin_in_nxt = 6'h00;
    end else if (wr_pend_r) begin
      unique case (wr_idx_r)
        pps_pkg::PPS_IDX_DATA: data_nxt = hwdata_i[5:0];
        pps_pkg::PPS_IDX_DIR: dir_nxt = hwdata_i[5:0];
        pps_pkg::PPS_IDX_PULLUP: pullup_nxt = hwdata_i[4:0];
        default: data_nxt = data_r;
      endcase
    end
  end

  // Registers the port state.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || ce_i) begin
      data_r <= data_nxt;
      dir_r <= dir_nxt;
      pullup_r <= pullup_nxt;
      pin_in_r <= pin_in_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin function per bit.

  logic [5:0] cell_out;
  logic [5:0] cell_oe;
  logic [5:0] cell_pu;
  logic [5:0] pu_en;

  // The top pin has no pull-up.
  assign pu_en = {1'b0, pullup_r};

  // One cell per pin resolves its drive, enable and pull-up.
  for (genvar g = 0; g < pps_pkg::PPS_NPINS; g++) begin : g_cell
    pps_pin_cell u_cell (
      .avail_i(avail[g]),
      .input_only_i(input_only[g]),
      .open_drain_i(open_drain[g]),
      .data_i(data_r[g]),
      .dir_i(dir_r[g]),
      .pu_en_i(pu_en[g]),
      .out_o(cell_out[g]),
      .oe_o(cell_oe[g]),
      .pu_o(cell_pu[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin output flops and the clockless reset gate.

  logic [5:0] out_r;
  logic [5:0] out_nxt;
  logic [5:0] oe_r;
  logic [5:0] oe_nxt;
  logic [5:0] pu_r;
  logic [5:0] pu_nxt;
  logic osc_in_r;
  logic osc_in_nxt;
  logic osc_out_r;
  logic osc_out_nxt;
  logic ext_rst_r;
  logic ext_rst_nxt;
  logic reset_active;

  // Cell results and oscillator claims are registered; cleared in reset.
  always_comb begin
    out_nxt = cell_out;
    oe_nxt = cell_oe;
    pu_nxt = cell_pu;
    osc_in_nxt = claim[0];
    osc_out_nxt = claim[1];
    ext_rst_nxt = cfg_ext_rst_r & ~port_pins_i[pps_pkg::PPS_TOP];
    if (!rst_n_i) begin
      out_nxt = 6'h00;
      oe_nxt = 6'h00;
      pu_nxt = 6'h00;
      osc_in_nxt = 1'b0;
      osc_out_nxt = 1'b0;
      ext_rst_nxt = 1'b0;
    end
  end

  // Registers the pin-facing state.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || ce_i) begin
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      pu_r <= pu_nxt;
      osc_in_r <= osc_in_nxt;
      osc_out_r <= osc_out_nxt;
      ext_rst_r <= ext_rst_nxt;
    end
  end

  // A low reset input, or a low top pin in reset mode, cuts every enable at once.
  assign reset_active = ~rst_n_i |
    (cfg_ext_rst_r & ~port_pins_i[pps_pkg::PPS_TOP]);
  assign port_pins_oe_o = oe_r & {6{~reset_active}};
  assign port_pins_pu_o = pu_r & {6{~reset_active}};
  assign port_pins_o = out_r;
  assign osc_amp_input_sel_o = osc_in_r;
  assign osc_amp_output_sel_o = osc_out_r;
  assign ext_reset_req_o = ext_rst_r;

endmodule

// ===== test/pps_board_model.sv
// Purpose: Board side of the six port pins.
// Assumes: Board resistors weakly hold each line at drive_val_i.
// Notes: A design drive wins over the weak board level.
`timescale 1ns/1ps
module pps_board_model (
  input wire logic [5:0] oe_i,
  input wire logic [5:0] out_i,
  input wire logic [5:0] drive_val_i,
  output logic [5:0] level_o
);
  // Resolve each line; the top pin can only be pulled low by the design.
  always_comb begin
    level_o = drive_val_i;
    for (int i = 0; i < 5; i++) begin
      if (oe_i[i]) begin
        level_o[i] = out_i[i];
      end
    end
    if (oe_i[5]) begin
      level_o[5] = 1'b0;
    end
  end
endmodule

// ===== test/pps_sva.sv
// Purpose: Checker for the pin function select outputs.
// Assumes: Straps move only while reset is low.
// Notes: Bound into the top module.
`timescale 1ns/1ps
module pps_sva (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic cfg_ext_rst_en_i,
  input wire logic [2:0] cfg_clk_opt_i,
  input wire logic cfg_full_variant_i,
  input wire logic [5:0] port_pins_i,
  input wire logic [5:0] port_pins_o,
  input wire logic [5:0] port_pins_oe_o,
  input wire logic [5:0] port_pins_pu_o,
  input wire logic osc_amp_input_sel_o,
  input wire logic osc_amp_output_sel_o,
  input wire logic ext_reset_req_o
);
  // All checks sample on the system clock.
  default clocking @(posedge clk_sys_i); endclocking
  ////////////////////////////////////////////////////////////////////////////
  rst_tristate_a: assert property (
    !rst_n_i |-> (port_pins_oe_o | port_pins_pu_o) == 6'h00)
    else $error("pin enabled in reset");
  ext_tristate_a: assert property (
    disable iff (!rst_n_i) cfg_ext_rst_en_i && !port_pins_i[5] |->
    (port_pins_oe_o | port_pins_pu_o) == 6'h00)
    else $error("pin enabled in external reset");
  top_pin_a: assert property (
    disable iff (!rst_n_i) !port_pins_o[5] && !port_pins_pu_o[5])
    else $error("top pin high or pulled");
  reduced_in_a: assert property (
    disable iff (!rst_n_i) !cfg_full_variant_i |-> !port_pins_oe_o[5])
    else $error("reduced top pin driven");
  ext_rst_pin_a: assert property (
    disable iff (!rst_n_i) cfg_ext_rst_en_i |-> !port_pins_oe_o[5])
    else $error("reset pin driven");
  req_follow_a: assert property (
    disable iff (!rst_n_i) $past(rst_n_i) |->
    ext_reset_req_o == $past(cfg_ext_rst_en_i && !port_pins_i[5]))
    else $error("reset request wrong");
  osc_in_a: assert property (
    disable iff (!rst_n_i) $past(rst_n_i) |->
    osc_amp_input_sel_o == (cfg_clk_opt_i < 3'h5))
    else $error("fourth pin claim wrong");
  osc_out_a: assert property (
    disable iff (!rst_n_i) $past(rst_n_i) |->
    osc_amp_output_sel_o == (cfg_clk_opt_i < 3'h3))
    else $error("fifth pin claim wrong");
  claim_off_a: assert property (
    disable iff (!rst_n_i) ((port_pins_oe_o[4:3] | port_pins_pu_o[4:3])
    & {osc_amp_output_sel_o, osc_amp_input_sel_o}) == 2'h0)
    else $error("claimed pin used by port");
endmodule
bind pps_port_pin_function_select pps_sva chk_u (.*);

// ===== test/tb_top.sv
// Purpose: Self-checking bench for the port pin function select block.
// Assumes: Straps move only while reset is held low.
// Notes: Reads and pin snapshots are queued and checked by monitors.
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_i = 0, rst_n_i = 0, ce_i = 1, cfg_ext_rst_en_i = 0, cfg_full_variant_i = 0;
  logic hsel_i = 0, hwrite_i = 0, hready_i, run = 1, hreadyout_o, hresp_o, rd_live = 0;
  logic osc_amp_input_sel_o, osc_amp_output_sel_o, ext_reset_req_o;
  logic [2:0] cfg_clk_opt_i = 3'h0, hsize_i = 3'h2;
  logic [1:0] htrans_i = 2'h0;
  logic [5:0] port_pins_i, port_pins_o, port_pins_oe_o, port_pins_pu_o, drv = 6'h3f;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, s = 32'hf9aac4b7;
  logic [31:0] rd_q[$], pin_q[$];
  int miscompares = 0, checks_done = 0;
  event pin_ev;
  assign hready_i = hreadyout_o;
  pps_port_pin_function_select dut_u (.*);
  pps_board_model board_u (.oe_i(port_pins_oe_o), .out_i(port_pins_o), .drive_val_i(drv),
    .level_o(port_pins_i));
  // Clock, stoppable to show reset acting without it.
  always #2 if (run) clk_sys_i = ~clk_sys_i;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // One single transfer; for a read v is the expected word.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    do @(posedge clk_sys_i); while (hready_i !== 1'b1);
    htrans_i <= 2'h0;
    hsel_i <= 1'b0;
    hwdata_i <= w ? v : 32'h0;
    rd_live <= !w;
    if (!w) rd_q.push_back(v);
    do @(posedge clk_sys_i); while (hready_i !== 1'b1);
    rd_live <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Monitors take the oldest note when a result appears.
  always @(posedge clk_sys_i) begin
    if (rd_live && hready_i === 1'b1) begin
      check(hrdata_o, rd_q.pop_front());
      check({31'h0, hresp_o}, 32'h0);
    end
  end
  always @(pin_ev) begin
    check({11'h0, ext_reset_req_o, osc_amp_input_sel_o, osc_amp_output_sel_o, port_pins_oe_o,
      port_pins_o & port_pins_oe_o, port_pins_pu_o}, pin_q.pop_front());
  end
  // Watchdog ends a hung run.
  initial begin
    #50000;
    miscompares++;
    print_verdict();
  end
  // Every clock option under both reset settings and both variants.
  initial begin
    logic e, f;
    logic [2:0] o;
    logic [5:0] av, d, q, oe, ou, lv;
    logic [4:0] p;
    for (int c = 0; c < 24; c++) begin
      repeat (32) s = nx(s);
      o = 3'(c % 6);
      e = 1'((c / 6) % 2);
      f = 1'(c / 12);
      d = s[5:0];
      q = s[11:6];
      p = s[16:12];
      @(posedge clk_sys_i);
      rst_n_i <= 1'b0;
      cfg_clk_opt_i <= o;
      cfg_ext_rst_en_i <= e;
      cfg_full_variant_i <= f;
      drv <= {1'b1, s[21:17]};
      repeat (20) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      av = {!e, o > 3'h2, o > 3'h4, 3'h7};
      bus(1'b0, pps_pkg::PPS_OFF_STAT, {18'h0, av, 3'h0, f, e, o});
      bus(1'b1, 8'h14, 32'hffffffff);
      bus(1'b0, 8'h14, 32'h0);
      bus(1'b1, pps_pkg::PPS_OFF_DIR, {26'h0, d});
      bus(1'b1, pps_pkg::PPS_OFF_DATA, {26'h0, q});
      bus(1'b1, pps_pkg::PPS_OFF_PULLUP, {27'h0, p});
      bus(1'b0, pps_pkg::PPS_OFF_DIR, {26'h0, d});
      bus(1'b0, pps_pkg::PPS_OFF_PULLUP, {27'h0, p});
      oe = {av[5] & f & d[5] & !q[5], av[4:0] & d[4:0]};
      ou = {1'b0, q[4:0]} & oe;
      lv = (oe & ou) | (~oe & drv);
      pin_q.push_back({11'h0, 1'b0, o < 3'h5, o < 3'h3, oe, ou, 1'b0,
        av[4:0] & ~d[4:0] & p});
      -> pin_ev;
      bus(1'b0, pps_pkg::PPS_OFF_PIN, {26'h0, lv & av});
      if (e) begin
        drv[5] <= 1'b0;
        // Second edge: the reset request flop has taken the low pin by then.
        repeat (2) @(posedge clk_sys_i);
        pin_q.push_back({11'h0, 1'b1, o < 3'h5, o < 3'h3, 18'h0});
        -> pin_ev;
        drv[5] <= 1'b1;
      end
    end
    @(posedge clk_sys_i);
    run = 1'b0;
    #3 rst_n_i = 1'b0;
    #1 pin_q.push_back(32'h0);
    -> pin_ev;
    #1;
    print_verdict();
  end
endmodule
